// ---- rtl/energy_wake.v ----
`timescale 1ns/1ps
`include "wake_regs.vh"
module energy_wake #(
   parameter TICK = `TICK_CYCLES
)(
   input  wire        clk_i,        // Device clock
   input  wire        sys_rst_i,    // Async reset
   input  wire        ce_i,         // Clock enable
   input  wire        reg_wr_i,     // Register write strobe
   input  wire        reg_rd_i,     // Register read strobe
   input  wire [7:0]  reg_addr_i,   // Register byte address
   input  wire [15:0] reg_wdata_i,  // Write data
   output reg  [15:0] reg_rdata_o,  // Read data
   input  wire        energy_i,     // Cable energy present
   input  wire        link_up_i,    // Link up pulse
   input  wire [47:0] node_addr_i,  // Own station address
   input  wire        rx_sof_i,     // Frame start pulse
   input  wire        rx_valid_i,   // Rx byte strobe
   input  wire [7:0]  rx_data_i,    // Rx byte
   input  wire        rx_eof_i,     // Frame end pulse
   input  wire        rx_good_i,    // Frame valid, CRC good
   input  wire        rx_for_us_i,  // Address filter pass
   input  wire [15:0] rx_crc_i,     // Frame CRC summary, at end
   output wire        host_irq_n,   // Active-low host interrupt
   output reg         power_event_out, // Power event to system
   output reg         low_power_o,  // Low power state, circuits off
   output wire        cable_en_o    // Tx/Rx on cable permitted
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [15:0] power_mode_event_control;
   reg [15:0] sleep_wake_timing;
   reg [15:0] interrupt_enable;
   reg [15:0] interrupt_status;
   reg [15:0] wake_frame_control;
   reg [15:0] wake_def [0:3];
   reg [7:0]  sleep_cnt;
   reg [7:0]  wake_cnt;
   reg        ev_energy;
   reg        ev_frame;
   wire       tick;
   wire       seq_found;
   wire [1:0] pmode = power_mode_event_control[`PMODE_MSB:`PMODE_LSB];
   wire       in_energy = (pmode == `PMODE_ENERGY);
   wire       auto_wake = power_mode_event_control[`PM_AUTO_WAKE_BIT];
   wire       wake_norm = power_mode_event_control[`PM_WAKE_NORMAL_BIT];
   wire [7:0] sleep_lim = sleep_wake_timing[`TIM_SLEEP_MSB:`TIM_SLEEP_LSB];
   wire [7:0] wake_lim  = sleep_wake_timing[`TIM_WAKE_MSB:`TIM_WAKE_LSB];
   integer    i;

   function hit;
      input [7:0] a;
      input [7:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   unit_tick #(.CYCLES(TICK)) u_tick (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .ce_i      (ce_i),
      .tick_o    (tick)
   );

   seq_scan u_scan (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .ce_i        (ce_i),
      .enable_i    (wake_frame_control[`WFC_SEQ_EN_BIT]),
      .node_addr_i (node_addr_i),
      .rx_sof_i    (rx_sof_i),
      .rx_valid_i  (rx_valid_i),
      .rx_data_i   (rx_data_i),
      .rx_eof_i    (rx_eof_i),
      .rx_good_i   (rx_good_i),
      .rx_for_us_i (rx_for_us_i),
      .found_o     (seq_found)
   );

   // ----------------------------------------
   // Wake frame CRC match
   // ----------------------------------------
   reg frame_hit;
   always @*
   begin
      frame_hit = 1'b0;
      for (i = 0; i < 4; i = i + 1)
         if (wake_frame_control[i] && rx_crc_i == wake_def[i])
            frame_hit = 1'b1;
   end

   // ----------------------------------------
   // Energy detect state machine
   // ----------------------------------------
   localparam ST_NORMAL = 1'b0;
   localparam ST_LOW    = 1'b1;
   reg state;
   wire wake_qual = energy_i && tick && (wake_cnt >= wake_lim);
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state     <= ST_NORMAL;
         sleep_cnt <= 8'h00;
         wake_cnt  <= 8'h00;
         ev_energy <= 1'b0;
      end
      else if (ce_i)
      begin
         ev_energy <= 1'b0;
         if (!in_energy)
         begin
            state <= ST_NORMAL;
            sleep_cnt <= 8'h00;
            wake_cnt <= 8'h00;
         end
         else
         begin
            case (state)
               ST_NORMAL:
               begin
                  if (energy_i)
                     sleep_cnt <= 8'h00;
                  else if (tick)
                  begin
                     if (sleep_cnt >= sleep_lim)
                     begin
                        state <= ST_LOW;
                        sleep_cnt <= 8'h00;
                        wake_cnt <= 8'h00;
                     end
                     else
                        sleep_cnt <= sleep_cnt + 8'h01;
                  end
               end
               ST_LOW:
               begin
                  if (!energy_i)
                     wake_cnt <= 8'h00;
                  else if (wake_qual)
                  begin
                     ev_energy <= 1'b1;
                     wake_cnt <= 8'h00;
                     if (auto_wake)
                        state <= ST_NORMAL;
                  end
                  else if (tick && wake_cnt != 8'hFF)
                     wake_cnt <= wake_cnt + 8'h01;
                  if (reg_rd_i && hit(reg_addr_i, `GLOBAL_RESET_WAKE_OFS))
                     state <= ST_NORMAL;
               end
               default: state <= ST_NORMAL;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Register file and event flags
   // ----------------------------------------
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         power_mode_event_control <= `REG_RESET;
         sleep_wake_timing        <= `REG_RESET;
         interrupt_enable         <= `REG_RESET;
         interrupt_status         <= `REG_RESET;
         wake_frame_control       <= `REG_RESET;
         for (i = 0; i < 4; i = i + 1)
            wake_def[i] <= `REG_RESET;
         ev_frame        <= 1'b0;
         power_event_out <= 1'b0;
      end
      else if (ce_i)
      begin
         ev_frame <= rx_eof_i && rx_good_i && rx_for_us_i && frame_hit;
         if (reg_wr_i)
         begin
            case (reg_addr_i)
               `POWER_MODE_EVENT_OFS:  power_mode_event_control <= reg_wdata_i;
               `SLEEP_WAKE_TIMING_OFS: sleep_wake_timing <= reg_wdata_i;
               `INTERRUPT_ENABLE_OFS:  interrupt_enable <= reg_wdata_i;
               `WAKE_FRAME_CONTROL_OFS: wake_frame_control <= reg_wdata_i;
               `WAKE_FRAME0_DEF_OFS:   wake_def[0] <= reg_wdata_i;
               `WAKE_FRAME1_DEF_OFS:   wake_def[1] <= reg_wdata_i;
               `WAKE_FRAME2_DEF_OFS:   wake_def[2] <= reg_wdata_i;
               `WAKE_FRAME3_DEF_OFS:   wake_def[3] <= reg_wdata_i;
               default: ;
            endcase
         end
         // Write-one-to-clear, set wins over clear
         if (ev_energy && auto_wake && wake_norm)
            power_mode_event_control[`PMODE_MSB:`PMODE_LSB] <= `PMODE_NORMAL;
         interrupt_status <= (interrupt_status
            & ~((reg_wr_i && hit(reg_addr_i, `INTERRUPT_STATUS_OFS)) ? reg_wdata_i : 16'h0000))
            | ({15'h0000, ev_energy} << `IRQ_ENERGY_BIT)
            | ({15'h0000, link_up_i} << `IRQ_LINKUP_BIT)
            | ({15'h0000, seq_found} << `IRQ_SEQ_BIT)
            | ({15'h0000, ev_frame} << `IRQ_FRAME_BIT);
         if ((ev_energy && power_mode_event_control[`PM_EVT_OUT_EN_BIT])
             || seq_found
             || (ev_frame && power_mode_event_control[`PM_EVT_OUT_EN_BIT]))
            power_event_out <= 1'b1;
         else if (reg_rd_i && hit(reg_addr_i, `GLOBAL_RESET_WAKE_OFS))
            power_event_out <= 1'b0;
      end
   end

   assign host_irq_n = ~|(interrupt_status & interrupt_enable);

   // ----------------------------------------
   // Read mux and status outputs
   // ----------------------------------------
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         reg_rdata_o <= 16'h0000;
         low_power_o <= 1'b0;
      end
      else if (ce_i)
      begin
         low_power_o <= in_energy && (state == ST_LOW);
         case (reg_addr_i)
            `POWER_MODE_EVENT_OFS:   reg_rdata_o <= power_mode_event_control;
            `SLEEP_WAKE_TIMING_OFS:  reg_rdata_o <= sleep_wake_timing;
            `INTERRUPT_ENABLE_OFS:   reg_rdata_o <= interrupt_enable;
            `INTERRUPT_STATUS_OFS:   reg_rdata_o <= interrupt_status;
            `WAKE_FRAME_CONTROL_OFS: reg_rdata_o <= wake_frame_control;
            `WAKE_FRAME0_DEF_OFS:    reg_rdata_o <= wake_def[0];
            `WAKE_FRAME1_DEF_OFS:    reg_rdata_o <= wake_def[1];
            `WAKE_FRAME2_DEF_OFS:    reg_rdata_o <= wake_def[2];
            `WAKE_FRAME3_DEF_OFS:    reg_rdata_o <= wake_def[3];
            default:                 reg_rdata_o <= 16'h0000;
         endcase
      end
   end

   // Follows the registered state flag so both outputs switch together
   assign cable_en_o = ~low_power_o;
endmodule

// ---- rtl/wake_regs.vh ----
`ifndef WAKE_REGS_VH
`define WAKE_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GLOBAL_RESET_WAKE_OFS    8'h26
`define WAKE_FRAME_CONTROL_OFS   8'h2A
`define WAKE_FRAME0_DEF_OFS      8'h30
`define WAKE_FRAME1_DEF_OFS      8'h40
`define WAKE_FRAME2_DEF_OFS      8'h50
`define WAKE_FRAME3_DEF_OFS      8'h60
`define INTERRUPT_ENABLE_OFS     8'h90
`define POWER_MODE_EVENT_OFS     8'hD4
`define SLEEP_WAKE_TIMING_OFS    8'hD6
`define INTERRUPT_STATUS_OFS     8'h92
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMODE_LSB                0
`define PMODE_MSB                1
`define PM_WAKE_NORMAL_BIT       6
`define PM_AUTO_WAKE_BIT         7
`define PM_EVT_OUT_EN_BIT        8
`define IRQ_ENERGY_BIT           2
`define IRQ_LINKUP_BIT           3
`define IRQ_SEQ_BIT              4
`define IRQ_FRAME_BIT            5
`define WFC_SEQ_EN_BIT           7
`define TIM_SLEEP_LSB            0
`define TIM_SLEEP_MSB            7
`define TIM_WAKE_LSB             8
`define TIM_WAKE_MSB             15
// ----------------------------------------
// Power modes, reset values and sequence constants
// ----------------------------------------
`define PMODE_NORMAL             2'h0
`define PMODE_ENERGY             2'h1
`define PMODE_SOFT_DOWN          2'h2
`define PMODE_SAVING             2'h3
`define REG_RESET                16'h0000
`define SYNC_BYTE                8'hFF
`define SYNC_COUNT               3'h6
`define ADDR_COPIES              5'h10
// ----------------------------------------
// Timing
// ----------------------------------------
`define TIME_UNIT_NS             1000
`define CLK_PERIOD_NS            100
`define TICK_CYCLES              (`TIME_UNIT_NS / `CLK_PERIOD_NS)
`endif

// ---- rtl/unit_tick.v ----
`timescale 1ns/1ps
`include "wake_regs.vh"
module unit_tick #(
   parameter CYCLES = `TICK_CYCLES
)(
   input  wire clk_i,     // Device clock
   input  wire sys_rst_i, // Async reset
   input  wire ce_i,      // Clock enable
   output reg  tick_o     // One unit elapsed
);
   reg [15:0] cnt;
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt    <= 16'h0000;
         tick_o <= 1'b0;
      end
      else if (ce_i)
      begin
         tick_o <= (cnt == CYCLES[15:0] - 16'h0001);
         if (cnt == CYCLES[15:0] - 16'h0001)
            cnt <= 16'h0000;
         else
            cnt <= cnt + 16'h0001;
      end
   end
endmodule

// ---- rtl/seq_scan.v ----
`timescale 1ns/1ps
`include "wake_regs.vh"
module seq_scan (
   input  wire        clk_i,      // Device clock
   input  wire        sys_rst_i,  // Async reset
   input  wire        ce_i,       // Clock enable
   input  wire        enable_i,   // Scanning enabled
   input  wire [47:0] node_addr_i,// Own address, first byte in [47:40]
   input  wire        rx_sof_i,   // Frame start pulse
   input  wire        rx_valid_i, // Byte strobe
   input  wire [7:0]  rx_data_i,  // Byte
   input  wire        rx_eof_i,   // Frame end pulse
   input  wire        rx_good_i,  // Frame valid with good CRC, at end
   input  wire        rx_for_us_i,// DA station, multicast or broadcast
   output reg         found_o     // Sequence seen in good frame
);
   reg [2:0] ff_cnt;
   reg [4:0] copy_cnt;
   reg [2:0] byte_idx;
   reg       in_addr;
   reg       seen;
   function [7:0] addr_byte;
      input [47:0] a;
      input [2:0]  i;
      begin
         addr_byte = a[47 - 8*i -: 8];
      end
   endfunction
   wire [7:0] exp_byte = addr_byte(node_addr_i, byte_idx);
   always @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ff_cnt <= 3'h0; copy_cnt <= 5'h00; byte_idx <= 3'h0;
         in_addr <= 1'b0; seen <= 1'b0; found_o <= 1'b0;
      end
      else if (ce_i)
      begin
         found_o <= 1'b0;
         if (rx_sof_i)
         begin
            ff_cnt <= 3'h0; in_addr <= 1'b0; seen <= 1'b0;
         end
         else if (rx_valid_i && enable_i && !seen)
         begin
            if (in_addr && rx_data_i == exp_byte)
            begin
               if (byte_idx == 3'h5)
               begin
                  byte_idx <= 3'h0;
                  copy_cnt <= copy_cnt + 5'h01;
                  if (copy_cnt == `ADDR_COPIES - 5'h01)
                     seen <= 1'b1;
               end
               else
                  byte_idx <= byte_idx + 3'h1;
            end
            else if (rx_data_i == `SYNC_BYTE)
            begin
               // Extra FF keeps sync; addr starting with FF is not supported
               in_addr  <= (ff_cnt == `SYNC_COUNT - 3'h1) || (ff_cnt == `SYNC_COUNT);
               ff_cnt   <= (ff_cnt == `SYNC_COUNT) ? ff_cnt : ff_cnt + 3'h1;
               byte_idx <= 3'h0;
               copy_cnt <= 5'h00;
            end
            else
            begin
               in_addr <= 1'b0; ff_cnt <= 3'h0;
            end
         end
         if (rx_eof_i)
         begin
            found_o <= seen && rx_good_i && rx_for_us_i && enable_i;
            seen    <= 1'b0;
         end
      end
   end
endmodule

// ---- verification/host_cpu_model.sv ----
`timescale 1ns/1ps
module host_cpu_model (
   input  wire         clk_i,      // Device clock
   output logic        reg_wr_o,   // Write strobe
   output logic        reg_rd_o,   // Read strobe
   output logic [7:0]  reg_addr_o, // Register address
   output logic [15:0] reg_wdata_o // Write data
);
   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 16'h0000;
   end
   // Strobes change only after a falling edge, then held across one rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_i);
      reg_wr_o = 1'b1;
      reg_addr_o = a;
      reg_wdata_o = d;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_i);
      reg_rd_o = 1'b1;
      reg_addr_o = a;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
   endtask
   // Wake command without auto-wake
   task automatic wake;
      rd(8'h26);
   endtask
endmodule

// ---- verification/energy_wake_props.sv ----
`timescale 1ns/1ps
module energy_wake_props (
   input wire        clk_i,           // Device clock
   input wire        sys_rst_i,       // Async reset
   input wire        ce_i,            // Clock enable
   input wire        reg_wr_i,        // Write strobe
   input wire        reg_rd_i,        // Read strobe
   input wire [7:0]  reg_addr_i,      // Address
   input wire [15:0] reg_rdata_o,     // Read data
   input wire        energy_i,        // Cable energy
   input wire        link_up_i,       // Link up pulse
   input wire        rx_eof_i,        // Frame end
   input wire        rx_good_i,       // Good frame
   input wire        rx_for_us_i,     // Address match
   input wire        host_irq_n,      // Host interrupt
   input wire        power_event_out, // Power event
   input wire        low_power_o,     // Low power state
   input wire        cable_en_o       // Cable allowed
);
   logic [3:0] eof_q;
   logic [1:0] energy_q;
   logic [1:0] link_q;
   // Recent causes of an event
   always @(posedge clk_i or posedge sys_rst_i)
      if (sys_rst_i)
      begin
         eof_q <= 4'h0;
         energy_q <= 2'h0;
         link_q <= 2'h0;
      end
      else
      begin
         eof_q <= {eof_q[2:0], rx_eof_i & rx_good_i & rx_for_us_i};
         energy_q <= {energy_q[0], energy_i};
         link_q <= {link_q[0], link_up_i};
      end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   property p_reset_idle;
      $fell(sys_rst_i) |-> !power_event_out && host_irq_n && !low_power_o && cable_en_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
   property p_cable_gate;
      cable_en_o != low_power_o;
   endproperty
   a_cable_gate: assert property (p_cable_gate) else $error("cable enable wrong");
   property p_sleep_cause;
      $rose(low_power_o) |-> !$past(energy_i);
   endproperty
   a_sleep_cause: assert property (p_sleep_cause) else $error("slept with energy");
   property p_stay_low;
      low_power_o && !energy_i && !reg_rd_i && !reg_wr_i && !$past(reg_rd_i)
         && !$past(reg_wr_i) |=> low_power_o;
   endproperty
   a_stay_low: assert property (p_stay_low) else $error("left low power uncaused");
   property p_wake_cause;
      $fell(low_power_o) |-> $past(energy_i, 2) || $past(reg_wr_i, 2)
         || $past(reg_rd_i && reg_addr_i == 8'h26, 2);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("woke without cause");
   property p_event_sticky;
      $fell(power_event_out) |-> $past(reg_rd_i && reg_addr_i == 8'h26);
   endproperty
   a_event_sticky: assert property (p_event_sticky) else $error("event dropped early");
   property p_event_cause;
      $rose(power_event_out) |-> energy_q != 2'h0 || eof_q != 4'h0;
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("event without cause");
   property p_irq_cause;
      $fell(host_irq_n) |-> energy_q != 2'h0 || eof_q != 4'h0 || link_q != 2'h0
         || $past(reg_wr_i);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
   property p_zero_read;
      ce_i && (reg_addr_i == 8'h00 || reg_addr_i == 8'h26) |=> reg_rdata_o == 16'h0000;
   endproperty
   a_zero_read: assert property (p_zero_read) else $error("read data not zero");
endmodule
bind energy_wake energy_wake_props u_energy_wake_props (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
   .energy_i(energy_i), .link_up_i(link_up_i), .rx_eof_i(rx_eof_i), .rx_good_i(rx_good_i),
   .rx_for_us_i(rx_for_us_i), .host_irq_n(host_irq_n), .power_event_out(power_event_out),
   .low_power_o(low_power_o), .cable_en_o(cable_en_o)
);

// ---- verification/energy_wake_bench.sv ----
`timescale 1ns/1ps
module energy_wake_bench;
   localparam int          TICK = 2;
   localparam logic [47:0] NODE = 48'h1122_3344_5566;
   localparam logic [7:0]  RW_ADDR [7] = '{8'h2A, 8'h30, 8'h40, 8'h50, 8'h60, 8'h90, 8'hD6};
   logic        clk_i = 1'b0, sys_rst_i = 1'b1, energy_i = 1'b1, link_up_i = 1'b0;
   logic        rx_sof_i = 1'b0, rx_valid_i = 1'b0, rx_eof_i = 1'b0, rx_good_i = 1'b0;
   logic        rx_for_us_i = 1'b0, rd_q = 1'b0, reg_wr, reg_rd;
   logic        host_irq_n, power_event_out, low_power_o, cable_en_o;
   logic [7:0]  rx_data_i = 8'h00, reg_addr;
   logic [15:0] rx_crc_i = 16'h0000, reg_wdata, reg_rdata_o, crc;
   logic [15:0] exp_q[$];
   int          num_errors = 0, cmp_count = 0, cycles = 0;
   always #50 clk_i = ~clk_i;
   host_cpu_model u_host_cpu_model (
      .clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata)
   );
   energy_wake #(.TICK(TICK)) u_energy_wake (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata_o),
      .energy_i(energy_i), .link_up_i(link_up_i), .node_addr_i(NODE), .rx_sof_i(rx_sof_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_eof_i(rx_eof_i),
      .rx_good_i(rx_good_i), .rx_for_us_i(rx_for_us_i), .rx_crc_i(rx_crc_i),
      .host_irq_n(host_irq_n), .power_event_out(power_event_out), .low_power_o(low_power_o),
      .cable_en_o(cable_en_o)
   );
   task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_bit(input string name, input logic exp, input logic got);
      check_word(name, {15'h0000, exp}, {15'h0000, got});
   endtask
   task automatic test_done;
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      u_host_cpu_model.wr(a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      exp_q.push_back(exp);
      if (a == 8'h26)
         u_host_cpu_model.wake();
      else
         u_host_cpu_model.rd(a);
   endtask
   task automatic send_frame(input int copies, input logic good, input logic [15:0] fcs);
      logic [7:0] b[$];
      b = {8'h01, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      repeat (copies)
         for (int i = 5; i >= 0; i--)
            b.push_back(NODE[i*8 +: 8]);
      cyc(1);
      rx_sof_i = 1'b1;
      foreach (b[i])
      begin
         cyc(1);
         rx_sof_i = 1'b0;
         rx_valid_i = 1'b1;
         rx_data_i = b[i];
      end
      cyc(1);
      rx_valid_i = 1'b0;
      rx_data_i = ~rx_data_i;
      {rx_eof_i, rx_good_i, rx_for_us_i, rx_crc_i} = {1'b1, good, 1'b1, fcs};
      cyc(1);
      {rx_eof_i, rx_good_i, rx_for_us_i, rx_crc_i} = {3'h0, 16'($urandom)};
   endtask
   // Read results appear one edge after the read strobe is taken
   always @(posedge clk_i)
   begin
      rd_q <= reg_rd;
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         num_errors++;
         test_done();
      end
   end
   always @(negedge clk_i)
      if (rd_q === 1'b1)
         check_word("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
   initial
   begin
      void'($urandom(32'h61b6_9e57));
      cyc(4);
      sys_rst_i = 1'b0;
      check_bit("host_irq_n", 1'b1, host_irq_n);
      check_bit("cable_en_o", 1'b1, cable_en_o);
      foreach (RW_ADDR[i])
      begin
         crc = 16'($urandom);
         rd_chk(RW_ADDR[i], 16'h0000);
         wr(RW_ADDR[i], crc);
         rd_chk(RW_ADDR[i], crc);
      end
      for (int m = 0; m < 4; m++)
      begin
         wr(8'hD4, 16'(m));
         rd_chk(8'hD4, 16'(m));
      end
      wr(8'h00, 16'hFFFF);
      rd_chk(8'h00, 16'h0000);
      wr(8'h90, 16'h0004);
      wr(8'hD6, 16'h0403);
      wr(8'hD4, 16'h0101);
      energy_i = 1'b0;
      cyc(4);
      check_bit("low_power_o", 1'b0, low_power_o);
      cyc(12);
      check_bit("cable_en_o", 1'b0, cable_en_o);
      energy_i = 1'b1;
      cyc(6);
      energy_i = 1'b0;
      cyc(2);
      energy_i = 1'b1;
      cyc(6);
      check_bit("power_event_out", 1'b0, power_event_out);
      cyc(16);
      check_bit("power_event_out", 1'b1, power_event_out);
      check_bit("host_irq_n", 1'b0, host_irq_n);
      check_bit("low_power_o", 1'b1, low_power_o);
      rd_chk(8'h92, 16'h0004);
      rd_chk(8'h26, 16'h0000);
      cyc(1);
      check_bit("low_power_o", 1'b0, low_power_o);
      check_bit("power_event_out", 1'b0, power_event_out);
      wr(8'h92, 16'h0004);
      check_bit("host_irq_n", 1'b1, host_irq_n);
      for (int k = 0; k < 2; k++)
      begin
         wr(8'hD4, k ? 16'h00C1 : 16'h0081);
         energy_i = 1'b0;
         cyc(16);
         check_bit("low_power_o", 1'b1, low_power_o);
         energy_i = 1'b1;
         cyc(16);
         check_bit("low_power_o", 1'b0, low_power_o);
         check_bit("power_event_out", 1'b0, power_event_out);
         rd_chk(8'hD4, k ? 16'h00C0 : 16'h0081);
      end
      wr(8'h92, 16'hFFFF);
      link_up_i = 1'b1;
      cyc(1);
      link_up_i = 1'b0;
      rd_chk(8'h92, 16'h0008);
      wr(8'h2A, 16'h0080);
      for (int k = 0; k < 3; k++)
      begin
         wr(8'h92, 16'hFFFF);
         send_frame(k == 1 ? 15 : 16, k != 2, 16'($urandom));
         cyc(4);
         check_bit("power_event_out", k == 0, power_event_out);
         rd_chk(8'h92, k == 0 ? 16'h0010 : 16'h0000);
         rd_chk(8'h26, 16'h0000);
      end
      wr(8'h90, 16'h0020);
      for (int k = 0; k < 4; k++)
      begin
         crc = 16'($urandom);
         wr(8'h30 + 8'(k * 16), crc);
         wr(8'h2A, 16'(1 << k));
         send_frame(0, 1'b1, ~crc);
         cyc(4);
         check_bit("host_irq_n", 1'b1, host_irq_n);
         send_frame(0, 1'b1, crc);
         cyc(4);
         check_bit("host_irq_n", 1'b0, host_irq_n);
         rd_chk(8'h92, 16'h0020);
         wr(8'h92, 16'hFFFF);
      end
      cyc(2);
      test_done();
   end
endmodule
